/* File: logic/rx_cca_lqi_report.v */
// receive reporting: channel assessment, link quality, frame buffer, status registers
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`include "rx_report_defines.vh"

module rx_cca_lqi_report (
  input wire ref_clk,
  input wire rstn,
  input wire wbCyc,
  input wire wbStb,
  input wire wbWe,
  input wire [7:0] wbAdr,
  input wire [3:0] wbSel,
  input wire [31:0] wbDatW,
  output reg [31:0] wbDatR,
  output reg wbAck,
  input wire frameStart,
  input wire frameEnd,
  input wire octetValid,
  input wire [7:0] octetData,
  output reg octetReady,
  input wire [7:0] rxPowerDb,
  input wire carrierSense,
  input wire checksumOk,
  input wire corrValid,
  input wire [7:0] corrValue,
  input wire freqEstValid,
  input wire [11:0] freqEst,
  output reg ccaBusy,
  output reg rxStartEvent,
  output reg frameDoneEvent,
  output reg [11:0] freqCorrection
);
  reg [7:0] threshReg_q;
  reg [1:0] assessMode_q;
  reg checksumReg_q;
  reg [7:0] energyReg_q;
  reg lqiValid_q;
  reg [7:0] lqi_q;
  reg [10:0] corrSum_q;
  reg [3:0] corrCnt_q;
  reg [7:0] octetCnt_q;
  reg lqiPending_q;
  reg inFrame_q;
  reg freqLocked_q;
  reg [7:0] wrPtr_q;
  reg [7:0] rdPtr_q;
  reg [7:0] frameLen_q;
  reg [7:0] frameBuf [0:127];
  wire [8:0] fifoInData;
  wire fifoInValid;
  wire fifoInReady;
  wire fifoOutValid;
  wire fifoOutReady;
  wire [8:0] fifoOutData;
  wire [3:0] fifoLevel;
  wire busReq;
  wire [7:0] regIdx;
  wire edBusy;
  reg ccaBusy_d;
  reg [31:0] rdData_d;
  wire [7:0] lqiNow;
  wire [11:0] freqClamped;

  // saturate a signed ppm estimate to the tolerated range
  function [11:0] clampPpm;
    input [11:0] est;
    reg [11:0] negTol;
    begin
      negTol = 12'h000 - `FREQ_TOL_PPM;
      if (!est[11] && (est > `FREQ_TOL_PPM))
        clampPpm = `FREQ_TOL_PPM;
      else if (est[11] && (est < negTol))
        clampPpm = negTol;
      else
        clampPpm = est;
    end
  endfunction

  // bus decode: a request is taken once, ack follows one edge later
  assign busReq = wbCyc & wbStb & ~wbAck;
  assign regIdx = {2'h0, wbAdr[7:2]};

  // strict compare in dB above base: limit is twice the threshold field, bits 3:0 of the register
  assign edBusy = rxPowerDb > {3'h0, threshReg_q[`THRESH_MSB:`THRESH_LSB], 1'b0};

  // assessment decision per mode
  always @*
  begin
    case (assessMode_q)
      `MODE_CS_OR_ED: ccaBusy_d = carrierSense | edBusy;
      `MODE_ED_ONLY: ccaBusy_d = edBusy;
      `MODE_CS_ONLY: ccaBusy_d = carrierSense;
      `MODE_CS_AND_ED: ccaBusy_d = carrierSense & edBusy;
      default: ccaBusy_d = 1'b0;
    endcase
  end

  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      ccaBusy <= 1'b0;
    else
      ccaBusy <= ccaBusy_d;
  end

  // average of the first eight correlation results once MIN_LQI_OCTETS octets are in, else zero; sum of eight fits 8 bits after shift
  assign lqiNow = (octetCnt_q >= `MIN_LQI_OCTETS) ? corrSum_q[10:3] : 8'h00;

  // octets and the trailing quality byte share one queue, bit 8 marks the quality byte
  assign fifoInValid = (octetValid & octetReady & inFrame_q) | lqiPending_q;
  assign fifoInData = lqiPending_q ? {1'b1, lqi_q} : {1'b0, octetData};
  // drain stalls when the buffer is full, which backs up to octetReady
  assign fifoOutReady = (wrPtr_q != `BUF_FULL_PTR);

  rx_fifo #(
    .WIDTH(9),
    .DEPTH(8),
    .AW(3)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData),
    .level(fifoLevel)
  );

  // registered ready keeps one slot spare for the octet already in flight
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      octetReady <= 1'b0;
    else
      octetReady <= (fifoLevel < 4'h6) & ~lqiPending_q;
  end

  // frame tracking, link quality gathering and frequency estimate hold
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      inFrame_q <= 1'b0;
      corrSum_q <= 11'h000;
      corrCnt_q <= 4'h0;
      octetCnt_q <= 8'h00;
      lqi_q <= 8'h00;
      lqiPending_q <= 1'b0;
      freqLocked_q <= 1'b0;
      freqCorrection <= 12'h000;
      rxStartEvent <= 1'b0;
    end
    else
    begin
      rxStartEvent <= frameStart;
      if (frameStart)
      begin
        inFrame_q <= 1'b1;
        corrSum_q <= 11'h000;
        corrCnt_q <= 4'h0;
        octetCnt_q <= 8'h00;
        freqLocked_q <= 1'b0;
        freqCorrection <= 12'h000;
      end
      else if (inFrame_q)
      begin
        if (corrValid && (corrCnt_q < `LQI_SAMPLES))
        begin
          corrSum_q <= corrSum_q + {3'h0, corrValue};
          corrCnt_q <= corrCnt_q + 4'h1;
        end
        if (octetValid && octetReady && (octetCnt_q != 8'hFF))
          octetCnt_q <= octetCnt_q + 8'h01;
        // only the first estimate of a frame is taken, later ones ignored
        if (freqEstValid && !freqLocked_q)
        begin
          freqLocked_q <= 1'b1;
          freqCorrection <= 12'h000 - clampPpm(freqEst);
        end
        if (frameEnd)
        begin
          inFrame_q <= 1'b0;
          lqi_q <= lqiNow;
          lqiPending_q <= 1'b1;
        end
      end
      else
      begin
        // correction ends with the frame
        freqCorrection <= 12'h000;
        freqLocked_q <= 1'b0;
      end
      if (lqiPending_q && fifoInReady)
        lqiPending_q <= 1'b0;
    end
  end

  // buffer storage has no reset, pointers define content
  always @(posedge ref_clk)
  begin
    if (fifoOutValid && fifoOutReady)
      frameBuf[wrPtr_q[6:0]] <= fifoOutData[7:0];
  end

  // buffer pointers, status capture and frame done event
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr_q <= 8'h00;
      frameLen_q <= 8'h00;
      frameDoneEvent <= 1'b0;
      checksumReg_q <= 1'b0;
      energyReg_q <= 8'h00;
      lqiValid_q <= 1'b0;
    end
    else
    begin
      frameDoneEvent <= 1'b0;
      if (frameStart)
        wrPtr_q <= 8'h00;
      else if (fifoOutValid && fifoOutReady)
      begin
        wrPtr_q <= wrPtr_q + 8'h01;
        if (fifoOutData[8])
        begin
          // quality byte is in the buffer: frame is fully readable now
          frameDoneEvent <= 1'b1;
          frameLen_q <= wrPtr_q + 8'h01;
        end
      end
      if (inFrame_q && frameEnd)
      begin
        checksumReg_q <= checksumOk;
        energyReg_q <= rxPowerDb;
        lqiValid_q <= (octetCnt_q >= `MIN_LQI_OCTETS);
      end
    end
  end

  // read mux for the register file
  always @*
  begin
    rdData_d = 32'h00000000;
    case (regIdx)
      `IDX_CHECKSUM_STATUS: rdData_d[`CHECKSUM_OK_BIT] = checksumReg_q;
      `IDX_ENERGY_STATUS: rdData_d[7:0] = energyReg_q;
      `IDX_ASSESS_THRESHOLD: rdData_d[7:0] = threshReg_q;
      `IDX_ASSESS_CONTROL: rdData_d[1:0] = assessMode_q;
      `IDX_RX_STATUS: rdData_d[2:0] = {inFrame_q, lqiValid_q, ccaBusy};
      `IDX_FRAME_LENGTH: rdData_d[7:0] = frameLen_q;
      `IDX_BUFFER_DATA: rdData_d[7:0] = frameBuf[rdPtr_q[6:0]];
      default: rdData_d = 32'h00000000;
    endcase
  end

  // wishbone slave: one wait state, unmapped indexes ack and read zero
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wbAck <= 1'b0;
      wbDatR <= 32'h00000000;
      threshReg_q <= `THRESH_RESET;
      assessMode_q <= `MODE_RESET;
      rdPtr_q <= 8'h00;
    end
    else
    begin
      wbAck <= busReq;
      if (busReq && !wbWe)
        wbDatR <= rdData_d;
      if (frameStart)
        rdPtr_q <= 8'h00;
      else if (busReq && !wbWe && (regIdx == `IDX_BUFFER_DATA) && (rdPtr_q != `BUF_FULL_PTR))
        rdPtr_q <= rdPtr_q + 8'h01;
      if (busReq && wbWe && wbSel[0])
      begin
        if (regIdx == `IDX_ASSESS_THRESHOLD)
          threshReg_q <= wbDatW[7:0];
        if (regIdx == `IDX_ASSESS_CONTROL)
          assessMode_q <= wbDatW[1:0];
      end
    end
  end
endmodule // rx_cca_lqi_report

/* File: logic/rx_report_defines.vh */
// constants for the receive reporting block: register map, fields, resets, modes, limits
`ifndef RX_REPORT_DEFINES_VH
`define RX_REPORT_DEFINES_VH

// register indexes; byte address on the bus is four times the index
`define IDX_CHECKSUM_STATUS 8'h06
`define IDX_ENERGY_STATUS 8'h07
`define IDX_ASSESS_THRESHOLD 8'h09
`define IDX_ASSESS_CONTROL 8'h0A
`define IDX_RX_STATUS 8'h0B
`define IDX_FRAME_LENGTH 8'h0C
`define IDX_BUFFER_DATA 8'h0D

// field positions and reset values
`define THRESH_LSB 0
`define THRESH_MSB 3
`define THRESH_RESET 8'hC7
`define MODE_RESET 2'h1
`define CHECKSUM_OK_BIT 7

// assessment modes
`define MODE_CS_OR_ED 2'h0
`define MODE_ED_ONLY 2'h1
`define MODE_CS_ONLY 2'h2
`define MODE_CS_AND_ED 2'h3

// link quality and frame limits
`define LQI_SAMPLES 4'h8
`define MIN_LQI_OCTETS 8'h02
`define BUF_FULL_PTR 8'h80

// frequency offset tolerance in ppm, estimate unit is 1 ppm
`define FREQ_TOL_PPM 12'h078

`endif

/* File: logic/rx_fifo.v */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module rx_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire ref_clk,
  input wire rstn,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData,
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wrPtr_q;
  reg [AW:0] rdPtr_q;
  wire push;
  wire pop;

  // extra pointer bit separates full from empty
  assign level = wrPtr_q - rdPtr_q;
  assign inReady = (level != DEPTH[AW:0]);
  assign outValid = (level != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_q[AW-1:0]];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  // storage has no reset; only pointers define content
  always @(posedge ref_clk)
  begin
    if (push)
      mem[wrPtr_q[AW-1:0]] <= inData;
  end

  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr_q <= {(AW+1){1'b0}};
      rdPtr_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wrPtr_q <= wrPtr_q + {{AW{1'b0}}, 1'b1};
      if (pop)
        rdPtr_q <= rdPtr_q + {{AW{1'b0}}, 1'b1};
    end
  end
endmodule // rx_fifo

/* File: sim/rx_report_monitor.sv */
// port-level assertions for the receive reporting block
`timescale 1ns/1ps
module rx_report_monitor (
  input wire ref_clk,
  input wire rstn,
  input wire wbCyc,
  input wire wbStb,
  input wire wbWe,
  input wire [7:0] wbAdr,
  input wire [3:0] wbSel,
  input wire [31:0] wbDatW,
  input wire [31:0] wbDatR,
  input wire wbAck,
  input wire frameStart,
  input wire [7:0] rxPowerDb,
  input wire carrierSense,
  input wire ccaBusy,
  input wire rxStartEvent,
  input wire frameDoneEvent,
  input wire [11:0] freqCorrection
);
  reg [3:0] thrQ;
  reg [1:0] modeQ;
  wire take = wbCyc && wbStb && !wbAck && wbWe && wbSel[0];
  wire edHit = rxPowerDb > {3'h0, thrQ, 1'b0};
  wire busyExp = modeQ == 2'h0 ? (carrierSense | edHit) : modeQ == 2'h1 ? edHit :
    modeQ == 2'h2 ? carrierSense : (carrierSense & edHit);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // mirror of threshold and mode so the busy decision can be predicted
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      thrQ <= 4'h7;
      modeQ <= 2'h1;
    end
    else if (take && wbAdr[7:2] == 6'h09)
      thrQ <= wbDatW[3:0];
    else if (take && wbAdr[7:2] == 6'h0A)
      modeQ <= wbDatW[1:0];
  end
  a_ack_next: assert property ((wbCyc && wbStb && !wbAck) |=> wbAck)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (wbAck |=> !wbAck) else $error("ack longer than one cycle");
  a_read_upper: assert property ((wbAck && !$past(wbWe)) |-> wbDatR[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_busy_decision: assert property (
    $past(rstn) |-> ccaBusy == $past(busyExp)) else $error("busy decision wrong");
  a_start_event: assert property (frameStart |=> rxStartEvent)
    else $error("no start event after frame start");
  a_start_cause: assert property (rxStartEvent |-> $past(frameStart))
    else $error("start event without frame start");
  a_done_pulse: assert property (frameDoneEvent |=> !frameDoneEvent)
    else $error("frame done event too long");
  a_freq_range: assert property ($signed(freqCorrection) <= 12'sd120 &&
    $signed(freqCorrection) >= -12'sd120) else $error("frequency correction out of range");
  a_freq_once: assert property (
    ($past(freqCorrection) != 12'h000 && freqCorrection != 12'h000)
    |-> freqCorrection == $past(freqCorrection)) else $error("frequency correction changed");
endmodule // rx_report_monitor

bind rx_cca_lqi_report rx_report_monitor mon (.ref_clk(ref_clk), .rstn(rstn),
  .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
  .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .frameStart(frameStart),
  .rxPowerDb(rxPowerDb), .carrierSense(carrierSense), .ccaBusy(ccaBusy),
  .rxStartEvent(rxStartEvent), .frameDoneEvent(frameDoneEvent),
  .freqCorrection(freqCorrection));

/* File: sim/rx_front_model.sv */
// demodulator side model: frame start, correlations, octets under flow control, frame end
`timescale 1ns/1ps
module rx_front_model (
  input wire ref_clk,
  input wire octetReady,
  input wire frameDoneEvent,
  output logic frameStart,
  output logic frameEnd,
  output logic octetValid,
  output logic [7:0] octetData,
  output logic corrValid,
  output logic [7:0] corrValue,
  output logic freqEstValid,
  output logic [11:0] freqEst
);
  initial
  begin
    {frameStart, frameEnd, octetValid, corrValid, freqEstValid} = 5'h00;
    {octetData, corrValue, freqEst} = 28'h0;
  end
  // octets are numbered from 8'h10 so the bench can predict buffer contents
  task automatic sendFrame(input int n, input logic [7:0] corr, input logic [11:0] est);
    int i;
    int t;
    begin
      @(posedge ref_clk);
      frameStart <= 1'b1;
      @(posedge ref_clk);
      frameStart <= 1'b0;
      // estimate comes once the frame is open; on the start edge it would be dropped
      freqEstValid <= 1'b1;
      freqEst <= est;
      corrValue <= corr;
      corrValid <= 1'b1;
      @(posedge ref_clk);
      freqEst <= ~est; // later estimates of the frame must be ignored
      repeat (7) @(posedge ref_clk);
      corrValid <= 1'b0;
      freqEstValid <= 1'b0;
      corrValue <= ~corr;
      i = 0;
      while (i < n)
      begin
        octetValid <= 1'b1;
        octetData <= 8'h10 + i[7:0];
        @(posedge ref_clk);
        if (octetReady === 1'b1)
          i++;
      end
      octetValid <= 1'b0;
      octetData <= ~octetData; // released line must not look valid
      frameEnd <= 1'b1;
      @(posedge ref_clk);
      frameEnd <= 1'b0;
      t = 0;
      while (frameDoneEvent !== 1'b1 && t < 200)
      begin
        @(posedge ref_clk);
        t++;
      end
    end
  endtask
endmodule // rx_front_model

/* File: sim/tb_top.sv */
// bench for the receive reporting block: register access, assessment, frame buffer
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, rstn, wbCyc, wbStb, wbWe, carrierSense, checksumOk, expBusy, ed;
  logic [7:0] wbAdr, rxPowerDb;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, rd;
  logic [11:0] lastCorr;
  int startCount, doneCount;
  wire [31:0] wbDatR;
  wire [11:0] freqEst, freqCorrection;
  wire [7:0] octetData, corrValue;
  wire wbAck, frameStart, frameEnd, octetValid, octetReady, corrValid, freqEstValid;
  wire ccaBusy, rxStartEvent, frameDoneEvent;
  int failCount, numChecks, cyc, m, p, c, i;
  rx_cca_lqi_report dut (.ref_clk(ref_clk), .rstn(rstn), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR),
    .wbAck(wbAck), .frameStart(frameStart), .frameEnd(frameEnd), .octetValid(octetValid),
    .octetData(octetData), .octetReady(octetReady), .rxPowerDb(rxPowerDb),
    .carrierSense(carrierSense), .checksumOk(checksumOk), .corrValid(corrValid),
    .corrValue(corrValue), .freqEstValid(freqEstValid), .freqEst(freqEst),
    .ccaBusy(ccaBusy), .rxStartEvent(rxStartEvent), .frameDoneEvent(frameDoneEvent),
    .freqCorrection(freqCorrection));
  rx_front_model model (.ref_clk(ref_clk), .octetReady(octetReady),
    .frameDoneEvent(frameDoneEvent), .frameStart(frameStart), .frameEnd(frameEnd),
    .octetValid(octetValid), .octetData(octetData), .corrValid(corrValid),
    .corrValue(corrValue), .freqEstValid(freqEstValid), .freqEst(freqEst));
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task check(input string nm, input logic [31:0] seen, input logic [31:0] expv);
    numChecks++;
    if (seen !== expv)
    begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", nm, expv, seen);
    end
  endtask
  // classic cycle: hold everything until ack is sampled, then release
  task wbXfer(input logic we, input logic [7:0] idx, input logic [31:0] d);
    int t;
    begin
      @(posedge ref_clk);
      {wbCyc, wbStb, wbWe} <= {2'b11, we};
      wbAdr <= {idx[5:0], 2'b00};
      wbDatW <= d;
      t = 0;
      do
      begin
        @(posedge ref_clk);
        t++;
      end
      while (wbAck !== 1'b1 && t < 50);
      if (t >= 50)
        failCount++;
      rd = wbDatR;
      {wbCyc, wbStb} <= 2'b00;
    end
  endtask
  task readCheck(input string nm, input logic [7:0] idx, input logic [31:0] expv);
    wbXfer(1'b0, idx, 32'h0);
    check(nm, rd, expv);
  endtask
  task results;
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // cycle ceiling against a hang
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failCount++;
      results;
    end
  end
  // event pulses counted and the last non-zero correction kept for the frame checks
  always @(posedge ref_clk)
  begin
    if (rxStartEvent === 1'b1)
      startCount++;
    if (frameDoneEvent === 1'b1)
      doneCount++;
    if (freqCorrection !== 12'h000)
      lastCorr <= freqCorrection;
  end
  initial
  begin
    {rstn, wbCyc, wbStb, wbWe, carrierSense, checksumOk} = 6'h00;
    {wbAdr, rxPowerDb, wbDatW} = 48'h0;
    wbSel = 4'hF;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    readCheck("threshold", 8'h09, 32'h000000C7);
    readCheck("mode", 8'h0A, 32'h00000001);
    readCheck("checksum", 8'h06, 32'h0);
    readCheck("unmapped", 8'h20, 32'h0);
    wbXfer(1'b1, 8'h09, 32'h000000F5);
    readCheck("threshold rw", 8'h09, 32'h000000F5);
    $display("test registers done");
    for (m = 0; m < 4; m++)
    begin
      wbXfer(1'b1, 8'h0A, m);
      for (p = 10; p < 12; p++)
        for (c = 0; c < 2; c++)
        begin
          @(posedge ref_clk);
          rxPowerDb <= p;
          carrierSense <= c[0];
          repeat (2) @(posedge ref_clk);
          #1;
          ed = p > 10; // threshold 5 gives limit 10, equal stays idle
          expBusy = m == 0 ? (c[0] | ed) : m == 1 ? ed : m == 2 ? c[0] : (c[0] & ed);
          check("busy", {31'h0, ccaBusy}, {31'h0, expBusy});
        end
    end
    $display("test assessment done");
    rxPowerDb <= 8'h2A;
    carrierSense <= 1'b0;
    checksumOk <= 1'b1;
    model.sendFrame(4, 8'h5C, 12'h0C8);
    readCheck("length", 8'h0C, 32'h5);
    for (i = 0; i < 4; i++)
      readCheck("octet", 8'h0D, 32'h10 + i);
    readCheck("quality", 8'h0D, 32'h5C);
    readCheck("status", 8'h0B, 32'h2);
    readCheck("checksum", 8'h06, 32'h80);
    readCheck("energy", 8'h07, 32'h2A);
    check("start events", startCount, 32'h1);
    check("done events", doneCount, 32'h1);
    check("correction", {20'h0, lastCorr}, 32'h00000F88);
    $display("test long frame done");
    checksumOk <= 1'b0;
    model.sendFrame(1, 8'h33, 12'hF9C);
    readCheck("short length", 8'h0C, 32'h2);
    readCheck("short octet", 8'h0D, 32'h10);
    readCheck("short quality", 8'h0D, 32'h0);
    readCheck("short status", 8'h0B, 32'h0);
    readCheck("bad checksum", 8'h06, 32'h0);
    check("short start events", startCount, 32'h2);
    check("short done events", doneCount, 32'h2);
    check("short correction", {20'h0, lastCorr}, 32'h00000064);
    $display("test short frame done");
    results;
  end
endmodule // tb_top
